/* include/bsa_pkg.sv */
// constants, register map and filter decode for the battery sense converter control
// Operation
// - rates 4 Hz-8 kHz normal, 1 Hz-2 kHz low-power
// - sinc3 decimation gives one 16-bit word
// - current conversion counter interrupts at programmed count
// - current result above threshold raises interrupt
// - separately enabled fast over-range detection
// - accumulate 16-bit current results into 32 bits
// - current settles: third unchopped, second chopped
// - voltage settles: three unchopped, two chopped
// - temperature settles after switch: three/two cycles
// - attenuator routing by high-voltage config bit 7
// - temperature input: on-chip or external sensor
// - ground switch floats unless config bit 7
// - mode bit 6: direct or 20k ground
// - filter words map to 4/10/50/1k/8k rates
// - voltage out-of-range flag, clamp, clear in-range
package bsa_pkg;
  localparam int          MOD_RATE_HZ   = 512000;
  localparam int          ACC_W         = 54;
  localparam logic [15:0] FLT_4HZ       = 16'hbf1d;
  localparam logic [15:0] FLT_10HZ      = 16'h961f;
  localparam logic [15:0] FLT_50HZ      = 16'h007f;
  localparam logic [15:0] FLT_1KHZ      = 16'h0007;
  localparam logic [15:0] FLT_8KHZ      = 16'h0000;
  localparam logic [16:0] RATIO_4HZ     = 17'(MOD_RATE_HZ / 4);
  localparam logic [16:0] RATIO_10HZ    = 17'(MOD_RATE_HZ / 10);
  localparam logic [16:0] RATIO_50HZ    = 17'(MOD_RATE_HZ / 50);
  localparam logic [16:0] RATIO_1KHZ    = 17'(MOD_RATE_HZ / 1000);
  localparam logic [16:0] RATIO_8KHZ    = 17'(MOD_RATE_HZ / 8000);
  localparam logic [1:0]  SETTLE_CHOP   = 2'h2;
  localparam logic [1:0]  SETTLE_NOCHOP = 2'h3;
  localparam logic [5:0]  FAST_RUN      = 6'h30;
  // register byte offsets
  localparam logic [7:0]  OFS_CFG       = 8'h00;
  localparam logic [7:0]  OFS_MODE      = 8'h04;
  localparam logic [7:0]  OFS_FLT       = 8'h08;
  localparam logic [7:0]  OFS_HV        = 8'h0c;
  localparam logic [7:0]  OFS_STS       = 8'h10;
  localparam logic [7:0]  OFS_MASK      = 8'h14;
  localparam logic [7:0]  OFS_RES_I     = 8'h18;
  localparam logic [7:0]  OFS_RES_V     = 8'h1c;
  localparam logic [7:0]  OFS_RES_T     = 8'h20;
  localparam logic [7:0]  OFS_CNT_LIM   = 8'h24;
  localparam logic [7:0]  OFS_CNT       = 8'h28;
  localparam logic [7:0]  OFS_THRESH    = 8'h2c;
  localparam logic [7:0]  OFS_ACC       = 8'h30;
  // converter_config fields
  localparam int          CFG_EN_LSB    = 0;
  localparam int          CFG_CHOP      = 3;
  localparam int          CFG_LOWPWR    = 4;
  localparam int          CFG_ACC_EN    = 5;
  localparam int          CFG_FAST_EN   = 6;
  localparam int          CFG_GROUND_SWITCH_PIN    = 7;
  // converter_mode_reg / high_voltage_config fields
  localparam int          MODE_TEMP_EXT = 0;
  localparam int          MODE_GND_RES  = 6;
  localparam int          HV_ATTEN      = 7;
  // status fields: sticky events in 5:0, error levels in 14:12
  localparam int          STS_EV_W      = 6;
  localparam int          EV_CNT        = 3;
  localparam int          EV_THR        = 4;
  localparam int          EV_FAST       = 5;
  localparam int          STS_ERR_LSB   = 12;
  localparam logic [7:0]  CFG_RST       = 8'h00;
  localparam logic [7:0]  MODE_RST      = 8'h00;
  localparam logic [15:0] FLT_RST       = FLT_1KHZ;
  localparam logic [7:0]  HV_RST        = 8'h00;
  localparam logic [15:0] CNT_LIM_RST   = 16'h0000;
  localparam logic [15:0] THRESH_RST    = 16'h7fff;

  // filter word to modulator samples per result; unlisted words scale from 8 kHz
  function automatic logic [16:0] fltRatio(input logic [15:0] w);
    case (w)
      FLT_4HZ:  fltRatio = RATIO_4HZ;
      FLT_10HZ: fltRatio = RATIO_10HZ;
      FLT_50HZ: fltRatio = RATIO_50HZ;
      FLT_1KHZ: fltRatio = RATIO_1KHZ;
      FLT_8KHZ: fltRatio = RATIO_8KHZ;
      default:  fltRatio = 17'(RATIO_8KHZ * ({10'h000, w[6:0]} + 17'h00001));
    endcase
  endfunction
endpackage

/* include/bsa_chan_if.sv */
// control and result signals between the top and one channel decimator
interface bsa_chan_if;
  logic        clr;
  logic        en;
  logic        chop;
  logic        modStb;
  logic        modBit;
  logic [16:0] ratio;
  logic [15:0] data;
  logic        vld;
  logic        ovr;
  modport ctl  (output clr, en, chop, modStb, modBit, ratio, input data, vld, ovr);
  modport filt (input clr, en, chop, modStb, modBit, ratio, output data, vld, ovr);
endinterface

/* design/bsa_sinc3.sv */
// sinc3 decimator with settling suppression and full-scale clamp
module bsa_sinc3
  import bsa_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  bsa_chan_if.filt  ch
);
  logic signed [ACC_W-1:0] int1_q, int2_q, int3_q, dly1_q, dly2_q, dly3_q;
  logic        [16:0]      smpCnt_q;
  logic        [1:0]       outCnt_q;
  logic        [15:0]      data_q;
  logic                    vld_q, ovr_q;

  function automatic logic [5:0] ceilLog2(input logic [16:0] n);
    ceilLog2 = 6'h00;
    for (int i = 0; i < 17; i++) begin
      if ((17'h00001 << i) < n) ceilLog2 = 6'(i + 1);
    end
  endfunction

  wire signed [ACC_W-1:0] inSample = ch.modBit ? ACC_W'(1) : -ACC_W'(1);
  wire signed [ACC_W-1:0] comb1    = int3_q - dly1_q;
  wire signed [ACC_W-1:0] comb2    = comb1 - dly2_q;
  wire signed [ACC_W-1:0] comb3    = comb2 - dly3_q;
  wire        [5:0]       lg       = ceilLog2(ch.ratio);
  wire        [5:0]       shAmt    = (lg > 6'h05) ? 6'(3 * lg - 6'd15) : 6'h00;
  wire signed [ACC_W-1:0] scaled   = comb3 >>> shAmt;
  wire                    overPos  = scaled > ACC_W'(32767);
  wire                    overNeg  = scaled < -ACC_W'(32768);
  wire                    lastSmp  = ch.modStb && (smpCnt_q >= ch.ratio - 17'h00001);
  wire        [1:0]       settle   = ch.chop ? SETTLE_CHOP : SETTLE_NOCHOP;
  wire                    settled  = outCnt_q >= settle - 2'h1;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {int1_q, int2_q, int3_q, dly1_q, dly2_q, dly3_q} <= '0;
      smpCnt_q <= '0;
      outCnt_q <= '0;
      data_q   <= '0;
      vld_q    <= 1'b0;
      ovr_q    <= 1'b0;
    end else if (ch.clr || !ch.en) begin
      {int1_q, int2_q, int3_q, dly1_q, dly2_q, dly3_q} <= '0;
      smpCnt_q <= '0;
      outCnt_q <= '0;
      vld_q    <= 1'b0;
    end else begin
      vld_q <= 1'b0;
      if (ch.modStb) begin
        int1_q   <= int1_q + inSample;
        int2_q   <= int2_q + int1_q;
        int3_q   <= int3_q + int2_q;
        smpCnt_q <= lastSmp ? 17'h00000 : smpCnt_q + 17'h00001;
      end
      if (lastSmp) begin
        dly1_q <= int3_q;
        dly2_q <= comb1;
        dly3_q <= comb2;
        // earlier words are unsettled and never leave the filter
        if (settled) begin
          data_q <= overPos ? 16'h7fff : overNeg ? 16'h8000 : scaled[15:0];
          ovr_q  <= overPos || overNeg;
          vld_q  <= 1'b1;
        end else begin
          outCnt_q <= outCnt_q + 2'h1;
        end
      end
    end
  end

  assign ch.data = data_q;
  assign ch.vld  = vld_q;
  assign ch.ovr  = ovr_q;
endmodule  // bsa_sinc3

/* design/bsa_conv_ctrl.sv */
// top of the battery sense converter control: registers, three channels, current channel logic
//
// Our own choices: the address-and-strobe port and the address map.
module bsa_conv_ctrl
  import bsa_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  input  wire logic [2:0]  modStb,
  input  wire logic [2:0]  modBit,
  output logic      [31:0] rdData_q,
  output logic             irq_q,
  output logic      [2:0]  resVld_q,
  output logic      [2:0]  chanEn_q,
  output logic             chopOn_q,
  output logic             lowPower_q,
  output logic             attenEn_q,
  output logic             tempExtSel_q,
  output logic             gndSwConnect_q,
  output logic             gndSwViaRes_q
);
  localparam int NCH = 3;

  logic [7:0]          cfg_q, mode_q, hv_q;
  logic [15:0]         flt_q, cntLim_q, cnt_q, thresh_q;
  logic [31:0]         acc_q;
  logic [15:0]         res_q [NCH];
  logic [STS_EV_W-1:0] sts_q, mask_q;
  logic [NCH-1:0]      err_q;
  logic                restart_q;
  logic [5:0]          runLen_q;
  logic                lastBit_q;
  logic                fastHit_q;

  bsa_chan_if chIf [NCH] ();

  // register decode
  wire wrCfg    = wrStb && (addr == OFS_CFG);
  wire wrMode   = wrStb && (addr == OFS_MODE);
  wire wrFlt    = wrStb && (addr == OFS_FLT);
  wire wrHv     = wrStb && (addr == OFS_HV);
  wire wrMask   = wrStb && (addr == OFS_MASK);
  wire wrCntLim = wrStb && (addr == OFS_CNT_LIM);
  wire wrThresh = wrStb && (addr == OFS_THRESH);
  wire rdSts    = rdStb && (addr == OFS_STS);
  wire reconfig = wrCfg || wrMode || wrFlt;

  // channel results
  logic [NCH-1:0] chVld, chOvr;
  logic [15:0]    chData [NCH];
  wire  [16:0]    ratio = fltRatio(flt_q);

  for (genvar g = 0; g < NCH; g++) begin : g_chan
    assign chIf[g].clr    = restart_q;
    // the temperature channel restarts on a source switch, since mode writes restart
    assign chIf[g].en     = cfg_q[CFG_EN_LSB + g];
    assign chIf[g].chop   = cfg_q[CFG_CHOP];
    assign chIf[g].modStb = modStb[g];
    assign chIf[g].modBit = modBit[g];
    // low power slows the modulator, so the same ratio yields a quarter rate
    assign chIf[g].ratio  = ratio;
    assign chVld[g]       = chIf[g].vld;
    assign chOvr[g]       = chIf[g].ovr;
    assign chData[g]      = chIf[g].data;

    bsa_sinc3 u_filt (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ch      (chIf[g])
    );

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        res_q[g] <= '0;
        err_q[g] <= 1'b0;
      end else if (chVld[g]) begin
        res_q[g] <= chData[g];
        err_q[g] <= chOvr[g];
      end
    end
  end

  // current channel events
  wire         iVld     = chVld[0];
  wire  [15:0] iData    = chData[0];
  wire         iEn      = cfg_q[CFG_EN_LSB];
  wire  [15:0] cntNext  = cnt_q + 16'h0001;
  wire         cntHit   = iVld && (cntLim_q != 16'h0000) && (cntNext >= cntLim_q);
  wire         thrHit   = iVld && ($signed(iData) > $signed(thresh_q));
  wire         accClr   = reconfig || !iEn || !cfg_q[CFG_ACC_EN];
  wire  [31:0] accNext  = acc_q + {{16{iData[15]}}, iData};
  wire         sameBit  = modBit[0] == lastBit_q;
  wire         fastOn   = iEn && cfg_q[CFG_FAST_EN];
  wire         fastEv   = fastOn && modStb[0] && sameBit && (runLen_q == FAST_RUN - 6'h01) && !fastHit_q;

  wire [STS_EV_W-1:0] events = {fastEv, thrHit, cntHit, chVld};
  wire [STS_EV_W-1:0] stsNext = (sts_q & ~(rdSts ? {STS_EV_W{1'b1}} : '0)) | events;

  // read selection
  logic [31:0] rdMux;
  always_comb begin
    case (addr)
      OFS_CFG:     rdMux = {24'h000000, cfg_q};
      OFS_MODE:    rdMux = {24'h000000, mode_q};
      OFS_FLT:     rdMux = {16'h0000, flt_q};
      OFS_HV:      rdMux = {24'h000000, hv_q};
      OFS_STS:     rdMux = {17'h00000, err_q, 6'h00, sts_q};
      OFS_MASK:    rdMux = {26'h0000000, mask_q};
      OFS_RES_I:   rdMux = {16'h0000, res_q[0]};
      OFS_RES_V:   rdMux = {16'h0000, res_q[1]};
      OFS_RES_T:   rdMux = {16'h0000, res_q[2]};
      OFS_CNT_LIM: rdMux = {16'h0000, cntLim_q};
      OFS_CNT:     rdMux = {16'h0000, cnt_q};
      OFS_THRESH:  rdMux = {16'h0000, thresh_q};
      OFS_ACC:     rdMux = acc_q;
      default:     rdMux = 32'h00000000;
    endcase
  end

  // configuration registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_q    <= CFG_RST;
      mode_q   <= MODE_RST;
      flt_q    <= FLT_RST;
      hv_q     <= HV_RST;
      mask_q   <= '0;
      cntLim_q <= CNT_LIM_RST;
      thresh_q <= THRESH_RST;
    end else begin
      if (wrCfg) cfg_q <= wrData[7:0];
      if (wrMode) mode_q <= wrData[7:0];
      if (wrFlt) flt_q <= wrData[15:0];
      if (wrHv) hv_q <= wrData[7:0];
      if (wrMask) mask_q <= wrData[STS_EV_W-1:0];
      if (wrCntLim) cntLim_q <= wrData[15:0];
      if (wrThresh) thresh_q <= wrData[15:0];
    end
  end

  // filters restart one cycle after any reconfiguration
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) restart_q <= 1'b0;
    else     restart_q <= reconfig;
  end

  // conversion counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)               cnt_q <= '0;
    else if (reconfig || !iEn) cnt_q <= '0;
    else if (cntHit)       cnt_q <= '0;
    else if (iVld)         cnt_q <= cntNext;
  end

  // accumulator
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)         acc_q <= '0;
    else if (accClr) acc_q <= '0;
    else if (iVld)   acc_q <= accNext;
  end

  // fast over-range: a long run of equal modulator bits means the input is pinned
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      runLen_q  <= '0;
      lastBit_q <= 1'b0;
      fastHit_q <= 1'b0;
    end else if (!fastOn) begin
      runLen_q  <= '0;
      fastHit_q <= 1'b0;
    end else if (modStb[0]) begin
      lastBit_q <= modBit[0];
      // a differing bit already starts a run of one
      if (!sameBit) begin
        runLen_q  <= 6'h01;
        fastHit_q <= 1'b0;
      end else if (runLen_q != FAST_RUN) begin
        runLen_q <= runLen_q + 6'h01;
      end
      if (fastEv) fastHit_q <= 1'b1;
    end
  end

  // status, interrupt and read port; a new event beats the read clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sts_q    <= '0;
      irq_q    <= 1'b0;
      rdData_q <= '0;
      resVld_q <= '0;
    end else begin
      sts_q    <= stsNext;
      irq_q    <= |(stsNext & mask_q);
      rdData_q <= rdStb ? rdMux : 32'h00000000;
      resVld_q <= chVld;
    end
  end

  // analog front-end controls
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chanEn_q       <= '0;
      chopOn_q       <= 1'b0;
      lowPower_q     <= 1'b0;
      attenEn_q      <= 1'b0;
      tempExtSel_q   <= 1'b0;
      gndSwConnect_q <= 1'b0;
      gndSwViaRes_q  <= 1'b0;
    end else begin
      chanEn_q       <= cfg_q[CFG_EN_LSB +: NCH];
      chopOn_q       <= cfg_q[CFG_CHOP];
      lowPower_q     <= cfg_q[CFG_LOWPWR];
      attenEn_q      <= hv_q[HV_ATTEN];
      tempExtSel_q   <= mode_q[MODE_TEMP_EXT];
      gndSwConnect_q <= cfg_q[CFG_GROUND_SWITCH_PIN];
      // resistor choice only matters while connected; floats otherwise
      gndSwViaRes_q  <= cfg_q[CFG_GROUND_SWITCH_PIN] && mode_q[MODE_GND_RES];
    end
  end
endmodule  // bsa_conv_ctrl

/* sim/bsa_conv_ctrl_properties.sv */
// port-level assertions for the converter control block
module bsa_conv_ctrl_props
  import bsa_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wrData,
  input wire logic        wrStb,
  input wire logic        rdStb,
  input wire logic [2:0]  modStb,
  input wire logic [31:0] rdData_q,
  input wire logic        irq_q,
  input wire logic [2:0]  resVld_q,
  input wire logic        chopOn_q,
  input wire logic        lowPower_q,
  input wire logic        attenEn_q,
  input wire logic        tempExtSel_q,
  input wire logic        gndSwConnect_q,
  input wire logic        gndSwViaRes_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // a second write right after reaches the output only in the cycle after the checked one
  property mirror_p(logic [7:0] ofs, logic b, logic o);
    wrStb && addr == ofs ##1 !(wrStb && addr == ofs) |=> o == $past(b, 2);
  endproperty
  gnd_connect_a: assert property (mirror_p(OFS_CFG, wrData[CFG_GROUND_SWITCH_PIN], gndSwConnect_q))
    else $error("ground switch level wrong");
  atten_mirror_a: assert property (mirror_p(OFS_HV, wrData[HV_ATTEN], attenEn_q))
    else $error("attenuator enable wrong");
  temp_mirror_a: assert property (mirror_p(OFS_MODE, wrData[MODE_TEMP_EXT], tempExtSel_q))
    else $error("temperature source wrong");
  chop_mirror_a: assert property (mirror_p(OFS_CFG, wrData[CFG_CHOP], chopOn_q))
    else $error("chop level wrong");
  lowpwr_mirror_a: assert property (mirror_p(OFS_CFG, wrData[CFG_LOWPWR], lowPower_q))
    else $error("low power level wrong");
  gnd_float_a: assert property (!gndSwConnect_q |-> !gndSwViaRes_q)
    else $error("resistor path while floating");
  vld_pulse_a: assert property ((resVld_q & $past(resVld_q)) == 3'h0)
    else $error("result strobe longer than one cycle");
  vld_cause_a: assert property (resVld_q[0] |->
    $past(modStb[0], 2) || $past(modStb[0], 3) || $past(modStb[0], 4))
    else $error("result without recent sample");
  rd_idle_a: assert property (!rdStb |=> rdData_q == 32'h0)
    else $error("read data outside read slot");
  rd_unmapped_a: assert property (rdStb && addr > OFS_ACC |=> rdData_q == 32'h0)
    else $error("unmapped read not zero");
  cov_vld: cover property (resVld_q[0] ##1 !resVld_q[0]);
  cov_irq: cover property ($rose(irq_q));
  cov_res: cover property (gndSwViaRes_q);
endmodule // bsa_conv_ctrl_props

bind bsa_conv_ctrl bsa_conv_ctrl_props bsa_conv_ctrl_props_inst (.ref_clk(ref_clk), .rst(rst), .addr(addr),
  .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .modStb(modStb), .rdData_q(rdData_q), .irq_q(irq_q),
  .resVld_q(resVld_q), .chopOn_q(chopOn_q), .lowPower_q(lowPower_q), .attenEn_q(attenEn_q),
  .tempExtSel_q(tempExtSel_q), .gndSwConnect_q(gndSwConnect_q), .gndSwViaRes_q(gndSwViaRes_q));

/* sim/bsa_mod_model.sv */
// modulator model: counted bit bursts, idle bit line keeps changing
module bsa_mod_model (
  input  wire logic       ref_clk,
  output logic      [2:0] modStb,
  output logic      [2:0] modBit
);
  timeunit 1ns;
  timeprecision 1ps;
  int         left [3] = '{default: 0};
  logic [2:0] ones = 3'h0;
  initial begin
    modStb = 3'h0;
    modBit = 3'h0;
  end
  // alternating bits sit at mid-scale, all ones drive full scale
  always @(posedge ref_clk) begin
    for (int c = 0; c < 3; c++) begin
      modStb[c] <= left[c] > 0;
      modBit[c] <= left[c] > 0 ? ones[c] | left[c][0] : ~modBit[c];
      if (left[c] > 0)
        left[c] <= left[c] - 1;
    end
  end
  task automatic burst(input logic [2:0] m, input int n, input logic one);
    for (int c = 0; c < 3; c++) begin
      if (m[c]) begin
        // nba so the strobe process sees the load at the next edge, never racing it
        left[c] <= n;
        ones[c] <= one;
      end
    end
    do
      @(posedge ref_clk);
    while (left[0] + left[1] + left[2] != 0);
  endtask
endmodule // bsa_mod_model

/* sim/tb_top.sv */
// self-checking bench for the converter control block
module tb_top
  import bsa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wrData = 32'h0;
  logic        wrStb = 1'b0;
  logic        rdStb = 1'b0;
  logic [2:0]  modStb, modBit, resVld_q, chanEn_q;
  logic [31:0] rdData_q;
  logic        irq_q, chopOn_q, lowPower_q, attenEn_q, tempExtSel_q, gndSwConnect_q, gndSwViaRes_q;
  int          err_total = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          vld [3] = '{default: 0};
  int          accExp;
  logic [31:0] thr;
  wire [3:0]   pins = {gndSwConnect_q, gndSwViaRes_q, tempExtSel_q, attenEn_q};
  int          chT [6] = '{0, 0, 1, 1, 2, 2};
  logic [7:0]  cfgT [6] = '{8'h01, 8'h09, 8'h02, 8'h0a, 8'h04, 8'h0c};
  logic [15:0] fltT [6] = '{FLT_8KHZ, FLT_1KHZ, FLT_8KHZ, FLT_50HZ, FLT_8KHZ, FLT_8KHZ};
  int          ratT [6] = '{RATIO_8KHZ, RATIO_1KHZ, RATIO_8KHZ, RATIO_50HZ, RATIO_8KHZ, RATIO_8KHZ};

  bsa_conv_ctrl bsa_conv_ctrl_inst (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .modStb(modStb), .modBit(modBit), .rdData_q(rdData_q), .irq_q(irq_q), .resVld_q(resVld_q),
    .chanEn_q(chanEn_q), .chopOn_q(chopOn_q), .lowPower_q(lowPower_q), .attenEn_q(attenEn_q),
    .tempExtSel_q(tempExtSel_q), .gndSwConnect_q(gndSwConnect_q), .gndSwViaRes_q(gndSwViaRes_q));
  bsa_mod_model bsa_mod_model_inst (.ref_clk(ref_clk), .modStb(modStb), .modBit(modBit));

  initial forever #2.5 ref_clk = ~ref_clk;
  // counted on the falling edge so the bench never races the strobe
  always @(negedge ref_clk)
    for (int c = 0; c < 3; c++)
      vld[c] += resVld_q[c];
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge ref_clk);
    wrStb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge ref_clk);
    rdStb <= 1'b0;
    #1 chk(rdData_q, e);
    @(posedge ref_clk);
  endtask
  task automatic settle(input int ch, input logic [7:0] cfg, input logic [15:0] flt, input int ratio);
    int v0;
    int n;
    n = int'(cfg[CFG_CHOP] ? SETTLE_CHOP : SETTLE_NOCHOP) * ratio;
    wr(OFS_FLT, {16'h0, flt});
    wr(OFS_MODE, {31'h0, ch == 2});
    wr(OFS_CFG, {24'h0, cfg});
    v0 = vld[ch];
    bsa_mod_model_inst.burst(3'h1 << ch, n - 1, 1'b0);
    repeat (8) @(posedge ref_clk);
    chk({29'h0, chanEn_q}, {29'h0, cfg[2:0]});
    chk(32'(vld[ch] - v0), 32'h0);
    bsa_mod_model_inst.burst(3'h1 << ch, 1, 1'b0);
    repeat (8) @(posedge ref_clk);
    chk(32'(vld[ch] - v0), 32'h1);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    void'($urandom(27));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rdc(OFS_FLT, 32'h7);
    rdc(OFS_THRESH, 32'h7fff);
    wr(8'hfc, 32'hffffffff);
    rdc(8'hfc, 32'h0);
    for (int i = 0; i < 16; i++) begin
      wr(OFS_CFG, {24'h0, i[0], 2'h0, i[3], 4'h0});
      wr(OFS_MODE, {25'h0, i[1], 5'h0, i[2]});
      wr(OFS_HV, {24'h0, i[3], 7'h0});
      @(negedge ref_clk);
      chk({28'h0, pins}, {28'h0, i[0], i[0] & i[1], i[2], i[3]});
      chk({31'h0, lowPower_q}, {31'h0, i[3]});
      @(posedge ref_clk);
    end
    for (int k = 0; k < 6; k++)
      settle(chT[k], cfgT[k], fltT[k], ratT[k]);
    thr = 32'($urandom_range(32'h7ffe, 0));
    wr(OFS_THRESH, thr);
    wr(OFS_CNT_LIM, 32'h2);
    wr(OFS_MASK, 32'h3f);
    wr(OFS_FLT, {16'h0, FLT_8KHZ});
    wr(OFS_MODE, 32'h0);
    wr(OFS_CFG, 32'h63);
    // the settling runs left the ready bits of all three channels set
    rdc(OFS_STS, 32'h7);
    bsa_mod_model_inst.burst(3'h3, 256, 1'b1);
    accExp = (256 / RATIO_8KHZ - (SETTLE_NOCHOP - 1)) * 32767;
    repeat (8) @(posedge ref_clk);
    #1 chk({31'h0, irq_q}, 32'h1);
    @(posedge ref_clk);
    rdc(OFS_RES_V, 32'h7fff);
    rdc(OFS_ACC, 32'(accExp));
    rdc(OFS_CNT, 32'h0);
    rdc(OFS_STS, 32'h303b);
    #1 chk({31'h0, irq_q}, 32'h0);
    @(posedge ref_clk);
    bsa_mod_model_inst.burst(3'h2, 192, 1'b0);
    repeat (8) @(posedge ref_clk);
    rdc(OFS_STS, 32'h1002);
    wr(OFS_CFG, 32'h63);
    rdc(OFS_ACC, 32'h0);
    test_done();
  end
endmodule // tb_top
